// ==== rtl/sdpm_pkg.sv ====
// shared widths, field positions, reset values and carrier types for the memory pin mux
package sdpm_pkg;

	// widths of the address paths and boot pins, and synchroniser depth
	localparam int CORE_W = 26;
	localparam int EXT_W = 24;
	localparam int RC_W = 12;
	localparam int BOOT_W = 4;
	localparam int SYNC_STAGES = 3;

	// linear bank address: pins 15..11 carry core bits 25..21
	localparam int LIN_PIN_LSB = 11;
	localparam int LIN_CORE_LSB = 21;
	localparam int LIN_W = 5;

	// interleaved bank address: pins 19..16 carry core bits 12..9
	localparam int ILV_PIN_LSB = 16;
	localparam int ILV_CORE_LSB = 9;
	localparam int ILV_W = 4;

	// row/column address: pins 10..1 carry row/col bits 9..0, bits 11..10 on dedicated pins
	localparam int RC_PIN_LSB = 1;
	localparam int RC_LOW_W = 10;
	localparam int RC_HI_LSB = 10;
	localparam int RC_HI_W = 2;

	// reset values
	localparam logic SEL0_SDRAM_RST = 1'b0;
	localparam logic SEL1_SDRAM_RST = 1'b1;
	localparam logic [3:0] BOOT_RST = 4'h0;
	localparam logic [23:0] ADDR_RST = 24'h000000;
	localparam logic [1:0] RC_HI_RST = 2'h0;

	// cycle mapping held for a whole bus cycle
	typedef enum logic [1:0] {
		MODE_EXT = 2'b00,
		MODE_SD_LIN = 2'b01,
		MODE_SD_ILV = 2'b10
	} sdpm_mode_e;

	// address sources from the core side
	typedef struct packed {
		logic [CORE_W-1:0] core_addr;
		logic [EXT_W-1:0] ext_addr;
		logic [RC_W-1:0] mem_row_col_addr;
	} sdpm_addr_s;

	// active-low select requests from the controllers
	typedef struct packed {
		logic sdram_select_first_n;
		logic sdram_select_second_n;
		logic general_select_two_n;
		logic general_select_three_n;
	} sdpm_sel_s;

endpackage

// ==== rtl/sdpm_sync.sv ====
// three-stage synchroniser with agreement-qualified output for pin inputs
`timescale 1ns/1ps
module sdpm_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic stable
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	if (W < 1) begin : g_chk
		$error("sdpm_sync: width must be at least one");
	end

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (ce) begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a value counts once stages two and three agree
	always_comb begin
		sync_out = s3_q;
		stable = (s2_q == s3_q);
	end
endmodule // sdpm_sync

// ==== rtl/sdpm_pin_mux.sv ====
// memory pin mux: shares address pins between bus and sdram cycles, and chip-select pins between sdram and general selects per a control bit
// Summary of operation
// RULE1 - In sdram cycles with linear banking, pins 15..11 carry core address bits 25..21.
// RULE2 - In sdram cycles with interleaved banking, pins 19..16 carry core address bits 12..9.
// RULE3 - Pins 10..1 carry the sdram row/column address in sdram cycles and bus address bits 10..1 otherwise.
// RULE4 - The first sdram select pin carries either the sdram select or general select two, per a control bit.
// RULE5 - The second sdram select pin carries either the sdram select or general select three, sdram after reset.
// RULE6 - During system reset the boot pins are sampled and set the boot mode.
// RULE7 - The board straps the boot pins so the second sdram select can act as boot select when needed.
// RULE8 - Outside sdram cycles all shared pins carry bus functions, and the mapping changes only at cycle starts; select pins follow their control bits instead.
`timescale 1ns/1ps
module sdpm_pin_mux #(
	parameter int BOOT_W = sdpm_pkg::BOOT_W
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic CE,
	input sdpm_pkg::sdpm_addr_s ADDR_IN,
	input sdpm_pkg::sdpm_sel_s SEL_IN,
	input wire logic CYC_START,
	input wire logic CYC_SDRAM,
	input wire logic INTERLEAVE,
	input wire logic CTRL_WR,
	input wire logic CTRL_SEL0_SDRAM,
	input wire logic CTRL_SEL1_SDRAM,
	input wire logic [BOOT_W-1:0] BOOT_PINS,
	output logic [sdpm_pkg::EXT_W-1:0] MEM_ADDR,
	output logic [sdpm_pkg::RC_HI_W-1:0] MEM_ADDR_HI,
	output logic SEL_PIN0_N,
	output logic SEL_PIN1_N,
	output logic SEL0_IS_SDRAM,
	output logic SEL1_IS_SDRAM,
	output logic [BOOT_W-1:0] BOOT_MODE
);
	if (BOOT_W != sdpm_pkg::BOOT_W) begin : g_chk
		$error("sdpm_pin_mux: boot width must match the boot pin count");
	end

	// picks the sdram or general select for a shared chip-select pin
	function automatic logic pick_sel(input logic use_sdram, input logic sd_n, input logic gen_n);
		pick_sel = use_sdram ? sd_n : gen_n;
	endfunction

	sdpm_pkg::sdpm_mode_e mode_q, mode_d, mode_now;
	logic [sdpm_pkg::EXT_W-1:0] addr_q, addr_d;
	logic [sdpm_pkg::RC_HI_W-1:0] rc_hi_q, rc_hi_d;
	logic sel0_sd_q, sel0_sd_d;
	logic sel1_sd_q, sel1_sd_d;
	logic pin0_q, pin0_d;
	logic pin1_q, pin1_d;
	logic [BOOT_W-1:0] boot_q, boot_d;
	logic [BOOT_W-1:0] boot_sync;
	logic boot_stable;

	// boot strap pins come from outside the clock domain
	sdpm_sync #(
		.W(BOOT_W)
	) u_boot_sync (
		.clk(MCLK),
		.ce(CE),
		.async_in(BOOT_PINS),
		.sync_out(boot_sync),
		.stable(boot_stable)
	);

	// mapping for this cycle, taken only at a cycle start
	always_comb begin
		mode_now = mode_q;
		if (CYC_START) begin // RULE8
			if (!CYC_SDRAM) begin
				mode_now = sdpm_pkg::MODE_EXT;
			end else if (INTERLEAVE) begin
				mode_now = sdpm_pkg::MODE_SD_ILV;
			end else begin
				mode_now = sdpm_pkg::MODE_SD_LIN;
			end
		end
		mode_d = mode_now;
	end

	// shared address pins
	always_comb begin
		addr_d = ADDR_IN.ext_addr; // RULE8
		rc_hi_d = ADDR_IN.mem_row_col_addr[sdpm_pkg::RC_HI_LSB +: sdpm_pkg::RC_HI_W];
		unique case (mode_now)
			sdpm_pkg::MODE_EXT: begin
				addr_d = ADDR_IN.ext_addr; // RULE8
			end
			sdpm_pkg::MODE_SD_LIN: begin
				addr_d[sdpm_pkg::LIN_PIN_LSB +: sdpm_pkg::LIN_W] =
					ADDR_IN.core_addr[sdpm_pkg::LIN_CORE_LSB +: sdpm_pkg::LIN_W]; // RULE1
				addr_d[sdpm_pkg::RC_PIN_LSB +: sdpm_pkg::RC_LOW_W] =
					ADDR_IN.mem_row_col_addr[sdpm_pkg::RC_LOW_W-1:0]; // RULE3
			end
			sdpm_pkg::MODE_SD_ILV: begin
				addr_d[sdpm_pkg::ILV_PIN_LSB +: sdpm_pkg::ILV_W] =
					ADDR_IN.core_addr[sdpm_pkg::ILV_CORE_LSB +: sdpm_pkg::ILV_W]; // RULE2
				addr_d[sdpm_pkg::RC_PIN_LSB +: sdpm_pkg::RC_LOW_W] =
					ADDR_IN.mem_row_col_addr[sdpm_pkg::RC_LOW_W-1:0]; // RULE3
			end
			default: begin
				addr_d = ADDR_IN.ext_addr;
			end
		endcase
	end

	// chip-select function bits and the two shared select pins
	always_comb begin
		sel0_sd_d = sel0_sd_q;
		sel1_sd_d = sel1_sd_q;
		if (CTRL_WR) begin
			sel0_sd_d = CTRL_SEL0_SDRAM; // RULE4
			sel1_sd_d = CTRL_SEL1_SDRAM; // RULE5
		end
		pin0_d = pick_sel(sel0_sd_q, SEL_IN.sdram_select_first_n, SEL_IN.general_select_two_n); // RULE4
		pin1_d = pick_sel(sel1_sd_q, SEL_IN.sdram_select_second_n, SEL_IN.general_select_three_n); // RULE5
	end

	// boot mode follows the settled pins while reset is held
	always_comb begin
		boot_d = boot_q;
		if (SRST && boot_stable) begin
			boot_d = boot_sync; // RULE6
		end
	end

	// all state registered here; reset wins over the clock enable
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			mode_q <= sdpm_pkg::MODE_EXT;
			addr_q <= sdpm_pkg::ADDR_RST;
			rc_hi_q <= sdpm_pkg::RC_HI_RST;
			sel0_sd_q <= sdpm_pkg::SEL0_SDRAM_RST;
			sel1_sd_q <= sdpm_pkg::SEL1_SDRAM_RST; // RULE5
			pin0_q <= 1'b1;
			pin1_q <= 1'b1;
			boot_q <= boot_d; // RULE6
		end else if (CE) begin
			mode_q <= mode_d;
			addr_q <= addr_d;
			rc_hi_q <= rc_hi_d;
			sel0_sd_q <= sel0_sd_d;
			sel1_sd_q <= sel1_sd_d;
			pin0_q <= pin0_d;
			pin1_q <= pin1_d;
			boot_q <= boot_d;
		end
	end

	// outputs straight from flip-flops
	always_comb begin
		MEM_ADDR = addr_q;
		MEM_ADDR_HI = rc_hi_q;
		SEL_PIN0_N = pin0_q;
		SEL_PIN1_N = pin1_q;
		SEL0_IS_SDRAM = sel0_sd_q;
		SEL1_IS_SDRAM = sel1_sd_q;
		BOOT_MODE = boot_q;
	end

	// checks on the pin mapping
	lin_bank_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE1
		(CE && mode_now == sdpm_pkg::MODE_SD_LIN) |=>
		MEM_ADDR[15:11] == $past(ADDR_IN.core_addr[25:21]))
		else $error("linear bank pins do not carry core bits 25..21");

	ilv_bank_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE2
		(CE && mode_now == sdpm_pkg::MODE_SD_ILV) |=>
		MEM_ADDR[19:16] == $past(ADDR_IN.core_addr[12:9]) && MEM_ADDR[15:11] == $past(ADDR_IN.ext_addr[15:11]))
		else $error("interleaved bank pins do not carry core bits 12..9");

	row_col_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE3
		(CE && mode_now != sdpm_pkg::MODE_EXT) |=>
		MEM_ADDR[10:1] == $past(ADDR_IN.mem_row_col_addr[9:0]))
		else $error("row/column address missing from low pins in sdram cycle");

	sel_first_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE4
		(CE && CTRL_WR) ##1 (CE && !CTRL_WR) |=>
		SEL_PIN0_N == ($past(CTRL_SEL0_SDRAM, 2) ? $past(SEL_IN.sdram_select_first_n)
			: $past(SEL_IN.general_select_two_n)))
		else $error("first select pin shows the wrong function");

	sel_second_a: assert property (@(posedge MCLK) // RULE5
		$fell(SRST) |-> SEL1_IS_SDRAM && SEL_PIN1_N)
		else $error("second select pin not in sdram function after reset");

	boot_capture_a: assert property (@(posedge MCLK) // RULE6
		(SRST && boot_stable) |=> BOOT_MODE == $past(boot_sync))
		else $error("boot mode not taken from settled boot pins");

	bus_cycle_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE8
		(CE && CYC_START && !CYC_SDRAM) ##1 (CE && !CYC_START)[*2] |=>
		MEM_ADDR == $past(ADDR_IN.ext_addr))
		else $error("shared pins not on bus functions outside sdram cycles");

	mode_hold_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE8
		!CYC_START |=> mode_q == $past(mode_q))
		else $error("pin mapping changed inside a cycle");

	bus_low_pins_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE3
		(CE && !SRST && mode_now == sdpm_pkg::MODE_EXT) |=>
		MEM_ADDR[10:1] == $past(ADDR_IN.ext_addr[10:1]))
		else $error("low pins do not carry bus address outside sdram cycles");

	row_col_hi_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE3
		(CE && !SRST) |=>
		MEM_ADDR_HI == $past(ADDR_IN.mem_row_col_addr[11:10]))
		else $error("dedicated row/column pins do not carry bits 11..10");

	func_load_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE4
		(CE && !SRST && CTRL_WR) |=>
		SEL0_IS_SDRAM == $past(CTRL_SEL0_SDRAM) && SEL1_IS_SDRAM == $past(CTRL_SEL1_SDRAM))
		else $error("select function bits not loaded by the control write");

	sel_second_fn_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE5
		(CE && !SRST && CTRL_WR) ##1 (CE && !CTRL_WR) |=>
		SEL_PIN1_N == ($past(CTRL_SEL1_SDRAM, 2) ? $past(SEL_IN.sdram_select_second_n)
			: $past(SEL_IN.general_select_three_n)))
		else $error("second select pin shows the wrong function");

	boot_hold_a: assert property (@(posedge MCLK) // RULE6
		!SRST |=> BOOT_MODE == $past(BOOT_MODE))
		else $error("boot mode changed outside reset");

	freeze_hold_a: assert property (@(posedge MCLK) disable iff (SRST) // RULE8
		(!CE && !SRST) |=>
		$stable(MEM_ADDR) && $stable(MEM_ADDR_HI) && $stable(SEL_PIN0_N) && $stable(SEL_PIN1_N))
		else $error("pins moved while the clock enable was low");
endmodule // sdpm_pin_mux

// ==== tb/sdpm_mem_model.sv ====
// far-side memory model: board boot straps and a boot device on the second select
`timescale 1ns/1ps
module sdpm_mem_model #(
	parameter logic [3:0] STRAP = 4'hA
) (
	input wire logic clk,
	input wire logic sel_n,
	input wire logic [23:0] addr,
	output logic [3:0] straps,
	output logic [23:0] last_addr_q
);
	// straps keep the second select as boot select
	assign straps = STRAP;
	// device latches the address on each selected edge
	always_ff @(posedge clk) begin
		if (sel_n == 1'b0) begin
			last_addr_q <= addr;
		end
	end
endmodule // sdpm_mem_model

// ==== tb/testbench.sv ====
// self-checking bench for the memory pin mux
`timescale 1ns/1ps
module testbench;
	logic MCLK, SRST, CE, CYC_START, CYC_SDRAM, INTERLEAVE, CTRL_WR, CTRL_SEL0_SDRAM, CTRL_SEL1_SDRAM, alt;
	sdpm_pkg::sdpm_addr_s ADDR_IN;
	sdpm_pkg::sdpm_sel_s SEL_IN;
	logic [3:0] BOOT_PINS, straps, BOOT_MODE;
	logic [23:0] MEM_ADDR, seen, x;
	logic [1:0] MEM_ADDR_HI;
	logic SEL_PIN0_N, SEL_PIN1_N, SEL0_IS_SDRAM, SEL1_IS_SDRAM;
	int n_fail, samples_checked;
	// boot pins follow the board straps unless overridden
	assign BOOT_PINS = alt ? 4'h3 : straps;
	sdpm_pin_mux u_sdpm_pin_mux (.MCLK(MCLK), .SRST(SRST), .CE(CE), .ADDR_IN(ADDR_IN), .SEL_IN(SEL_IN),
		.CYC_START(CYC_START), .CYC_SDRAM(CYC_SDRAM), .INTERLEAVE(INTERLEAVE), .CTRL_WR(CTRL_WR),
		.CTRL_SEL0_SDRAM(CTRL_SEL0_SDRAM), .CTRL_SEL1_SDRAM(CTRL_SEL1_SDRAM), .BOOT_PINS(BOOT_PINS),
		.MEM_ADDR(MEM_ADDR), .MEM_ADDR_HI(MEM_ADDR_HI), .SEL_PIN0_N(SEL_PIN0_N), .SEL_PIN1_N(SEL_PIN1_N),
		.SEL0_IS_SDRAM(SEL0_IS_SDRAM), .SEL1_IS_SDRAM(SEL1_IS_SDRAM), .BOOT_MODE(BOOT_MODE));
	sdpm_mem_model u_sdpm_mem_model (.clk(MCLK), .sel_n(SEL_PIN1_N), .addr(MEM_ADDR), .straps(straps),
		.last_addr_q(seen));
	// compare and count
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// reset for ten cycles with a chosen boot strap
	task automatic do_reset(input logic a);
		alt <= a;
		SRST <= 1'b1;
		repeat (10) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		#1;
	endtask
	// one bus cycle start, then output checked one edge later
	task automatic cyc(input logic sd, input logic il, input logic [25:0] c, input logic [23:0] e,
		input logic [11:0] r, input logic [23:0] exp, input string m);
		@(posedge MCLK);
		CYC_START <= 1'b1;
		CYC_SDRAM <= sd;
		INTERLEAVE <= il;
		ADDR_IN <= {c, e, r};
		@(posedge MCLK);
		CYC_START <= 1'b0;
		#1;
		chk(MEM_ADDR, exp, m);
		chk({22'h0, MEM_ADDR_HI}, {22'h0, r[11:10]}, m);
	endtask
	// linear bank cycle, seen by the device, held without a new start
	task automatic t_linear();
		x = 24'h5A5A5A;
		x[15:11] = 5'h15;
		x[10:1] = 10'h296;
		cyc(1'b1, 1'b0, 26'h2B4C3D1, 24'h5A5A5A, 12'hE96, x, "linear");
		@(posedge MCLK);
		#1;
		chk(seen, x, "device addr");
		@(posedge MCLK);
		ADDR_IN.ext_addr <= 24'hFFFFFF;
		CYC_SDRAM <= 1'b0;
		x[23:16] = 8'hFF;
		x[0] = 1'b1;
		@(posedge MCLK);
		#1;
		chk(MEM_ADDR, x, "held");
	endtask
	// interleaved bank cycle, then a plain bus cycle right behind it
	task automatic t_ilv_bus();
		x = 24'hA5A5A5;
		x[19:16] = 4'hB;
		x[10:1] = 10'h169;
		cyc(1'b1, 1'b1, 26'h1FFF6AB, 24'hA5A5A5, 12'h569, x, "ilv");
		cyc(1'b0, 1'b1, 26'h3FFFFFF, 24'h123456, 12'hFFF, 24'h123456, "bus");
	endtask
	// clock enable low freezes the pins and refuses a cycle start
	task automatic t_freeze();
		@(posedge MCLK);
		CE <= 1'b0;
		CYC_START <= 1'b1;
		CYC_SDRAM <= 1'b1;
		ADDR_IN.ext_addr <= 24'h0F0F0F;
		@(posedge MCLK);
		CYC_START <= 1'b0;
		@(posedge MCLK);
		#1;
		chk(MEM_ADDR, 24'h123456, "frozen");
		@(posedge MCLK);
		CE <= 1'b1;
		@(posedge MCLK);
		#1;
		chk(MEM_ADDR, 24'h0F0F0F, "thawed");
	endtask
	// all four function settings of the two shared selects
	task automatic t_sel();
		for (int i = 0; i < 4; i++) begin
			@(posedge MCLK);
			SEL_IN <= 4'h6;
			CTRL_WR <= 1'b1;
			CTRL_SEL0_SDRAM <= i[0];
			CTRL_SEL1_SDRAM <= i[1];
			@(posedge MCLK);
			CTRL_WR <= 1'b0;
			@(posedge MCLK);
			#1;
			chk({22'h0, SEL0_IS_SDRAM, SEL1_IS_SDRAM}, {22'h0, i[0], i[1]}, "func");
			chk({22'h0, SEL_PIN0_N, SEL_PIN1_N}, {22'h0, ~i[0], i[1]}, "pins");
		end
	endtask
	// boot pins ignored outside reset, taken again on a second reset
	task automatic t_boot();
		@(posedge MCLK);
		alt <= 1'b1;
		repeat (6) @(posedge MCLK);
		#1;
		chk({20'h0, BOOT_MODE}, 24'h00000A, "boot held");
		@(posedge MCLK);
		do_reset(1'b1);
		chk({20'h0, BOOT_MODE}, 24'h000003, "boot new");
		chk({22'h0, SEL0_IS_SDRAM, SEL1_IS_SDRAM}, 24'h000001, "func rst");
	endtask
	// counts, verdict and end of run
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// 100 MHz clock
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	// main sequence
	initial begin
		{SRST, CYC_START, CYC_SDRAM, INTERLEAVE, CTRL_WR, CTRL_SEL0_SDRAM, CTRL_SEL1_SDRAM, alt} = 8'h00;
		CE = 1'b1;
		ADDR_IN = '0;
		SEL_IN = 4'hB;
		n_fail = 0;
		samples_checked = 0;
		do_reset(1'b0);
		chk({20'h0, BOOT_MODE}, 24'h00000A, "boot");
		chk({20'h0, SEL0_IS_SDRAM, SEL1_IS_SDRAM, SEL_PIN0_N, SEL_PIN1_N}, 24'h000006, "defaults");
		t_linear();
		t_ilv_bus();
		t_freeze();
		t_sel();
		t_boot();
		results();
	end
	// watchdog against a hang
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule // testbench
